// ==== logic/seq_timer.sv ====
// One-shot down-counting timer used for the minimum-active and transition times.
// Assumes load is a one-cycle strobe from logic on the same clock.
`timescale 1ns/1ps
module seq_timer
	import smps_pt_pkg::*;
#(
	parameter int unsigned CYCLES = 16,
	parameter int unsigned WIDTH = 24
)(
	input wire logic clk,
	input wire logic rstn,
	timer_if.tmr tif
);
	typedef struct packed {
		logic [WIDTH-1:0] count;
		logic done;
	} tmr_state_s;

	tmr_state_s s;
	tmr_state_s next_s;

	always_comb
	begin
		next_s = s;
		if (tif.load)
		begin
			next_s.count = WIDTH'(CYCLES - 1);
			next_s.done = 1'b0;
		end
		else if (!s.done)
		begin
			if (s.count == '0)
				next_s.done = 1'b1;
			else
				next_s.count = s.count - WIDTH'(1);
		end
	end

	// Expired after reset so a fresh start is not held back
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			s <= '{count: '0, done: 1'b1};
		else
			s <= next_s;
	end

	assign tif.done = s.done;
endmodule // seq_timer

// ==== logic/smps_mode_ctrl.sv ====
// Mode controller of the buck/boost supply: start-up, pass-through entry and exit.
// Assumes analog indicator pins are asynchronous and an AXI4-Lite master on clk.
`timescale 1ns/1ps
// Summary of operation
// - Start switching once input exceeds power-on level, no output voltage needed.
// - Coil current limit ramps up slowly during start-up.
// - In pass-through both high switches stay closed.
// - Enter pass-through only with mode 11, no over/undervoltage, no overtemperature; overcurrent is not checked.
// - Leave pass-through on undervoltage, overvoltage, overtemperature or overcurrent.
// - Minimum-active timer starts when switching resumes; return waits for it.
// - After timer expiry retry pass-through if mode 11 and voltage is fine.
// - Overcurrent after an attempt reactivates switching after the transition time.
// - Returning to switching keeps the output above its setting.
// - Entry ramps duty gradually; at full duty only filler pulses remain.
// - After transition time, analog switching modules off, overcurrent detect on.
// - In pass-through the controller stays active, pulsing and monitoring.
// - On exit analog restarts with switching suspended until output below target.
// - Bootstrap charge only when bootstrap voltage low, at reduced rate.
module smps_mode_ctrl
	import smps_pt_pkg::*;
#(
	parameter int unsigned MIN_ACTIVE_CNT = MIN_ACTIVE_CYCLES,
	parameter int unsigned TRANSITION_CNT = TRANSITION_CYCLES
)(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] indicatorPins,
	output logic inputHighSwitch,
	output logic outputHighSwitch,
	output logic switchEnable,
	output logic dutyRamp,
	output logic fillerPulse,
	output logic analogEnable,
	output logic ocDetectEnable,
	output logic [3:0] coilLimit,
	output logic [4:0] ctrlState,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	typedef struct packed {
		ctrl_state_e state;
		logic [7:0] syncA;
		logic [7:0] syncB;
		logic [1:0] modeSel;
		logic [3:0] coilLimit;
		logic [7:0] rampCnt;
		logic fullSeen;
		logic [8:0] fillGap;
		logic [3:0] fillWidth;
		logic inHigh;
		logic outHigh;
		logic swEn;
		logic ramp;
		logic filler;
		logic analogEn;
		logic ocDetEn;
		logic awready;
		logic awHeld;
		logic [11:0] awAddr;
		logic wready;
		logic wHeld;
		logic [1:0] wData;
		logic wStrb0;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ctrl_s;

	ctrl_s s;
	ctrl_s next_s;
	logic loadMin;
	logic loadTrans;
	logic por, uv, ov, otw, oc, full, bootLow, below;
	logic exitCause;
	timer_if minIf ();
	timer_if transIf ();

	function automatic logic hitReg(input logic [11:0] addr, input logic [11:0] offset);
		hitReg = ({addr[11:2], 2'h0} == offset);
	endfunction

	// ==========================================================
	// Timers
	seq_timer #(.CYCLES(MIN_ACTIVE_CNT), .WIDTH(24)) minTimer (
		.clk(clk),
		.rstn(rstn),
		.tif(minIf.tmr)
	);
	seq_timer #(.CYCLES(TRANSITION_CNT), .WIDTH(24)) transTimer (
		.clk(clk),
		.rstn(rstn),
		.tif(transIf.tmr)
	);
	assign minIf.load = loadMin;
	assign transIf.load = loadTrans;

	assign por = s.syncB[IDX_POR];
	assign uv = s.syncB[IDX_UV];
	assign ov = s.syncB[IDX_OV];
	assign otw = s.syncB[IDX_OTW];
	assign oc = s.syncB[IDX_OC];
	assign full = s.syncB[IDX_FULL];
	assign bootLow = s.syncB[IDX_BOOT];
	assign below = s.syncB[IDX_BELOW];
	assign exitCause = uv || ov || otw;

	// ==========================================================
	// Next state
	always_comb
	begin
		next_s = s;
		loadMin = 1'b0;
		loadTrans = 1'b0;
		next_s.syncA = indicatorPins;
		next_s.syncB = s.syncA;
		if (!por)
		begin
			next_s.state = ST_START;
			next_s.coilLimit = COIL_LIMIT_RESET;
			next_s.rampCnt = '0;
		end
		else
		begin
			unique case (s.state)
				ST_START:
				begin
					// Slow limit steps avoid inrush and overshoot
					if (s.rampCnt == 8'(SOFT_STEP_CYCLES - 1))
					begin
						next_s.rampCnt = '0;
						if (s.coilLimit == COIL_LIMIT_MAX)
						begin
							next_s.state = ST_SWITCH;
							loadMin = 1'b1;
						end
						else
							next_s.coilLimit = s.coilLimit + 4'h1;
					end
					else
						next_s.rampCnt = s.rampCnt + 8'h1;
				end
				ST_SWITCH:
				begin
					// Overcurrent cannot be seen while switching, so only voltage and temperature gate
					if (minIf.done && s.modeSel == MODE_PASSTHROUGH && !uv && !ov && !otw)
					begin
						next_s.state = ST_ENTER;
						next_s.fullSeen = 1'b0;
						loadTrans = 1'b1;
					end
				end
				ST_ENTER:
				begin
					if (full)
						next_s.fullSeen = 1'b1;
					if (exitCause || s.modeSel != MODE_PASSTHROUGH)
						next_s.state = ST_LEAVE;
					else if (transIf.done)
						next_s.state = ST_PASS;
				end
				ST_PASS:
				begin
					if (exitCause || oc || s.modeSel != MODE_PASSTHROUGH)
						next_s.state = ST_LEAVE;
				end
				ST_LEAVE:
				begin
					// Output still high from the input; wait for it to sink
					if (below)
					begin
						next_s.state = ST_SWITCH;
						loadMin = 1'b1;
					end
				end
			endcase
		end

		// Bootstrap filler pulses once switching has stopped
		if (next_s.state == ST_PASS || (next_s.state == ST_ENTER && next_s.fullSeen))
		begin
			if (s.fillGap != '0)
				next_s.fillGap = s.fillGap - 9'h1;
			if (s.fillWidth != '0)
				next_s.fillWidth = s.fillWidth - 4'h1;
			else if (s.fillGap == '0 && bootLow)
			begin
				next_s.fillWidth = FILL_WIDTH_CYCLES;
				next_s.fillGap = FILL_GAP_CYCLES;
			end
		end
		else
		begin
			next_s.fillGap = '0;
			next_s.fillWidth = '0;
		end

		// No switching until the input has passed the power-on level
		next_s.swEn = (next_s.state == ST_START && por) || (next_s.state == ST_SWITCH)
			|| (next_s.state == ST_ENTER && !next_s.fullSeen);
		next_s.ramp = (next_s.state == ST_ENTER);
		next_s.inHigh = (next_s.state == ST_PASS)
			|| (next_s.state == ST_ENTER && next_s.fullSeen);
		next_s.outHigh = next_s.inHigh;
		next_s.filler = (next_s.fillWidth != '0);
		next_s.analogEn = (next_s.state != ST_PASS);
		next_s.ocDetEn = (next_s.state == ST_PASS);

		// ==========================================================
		// AXI4-Lite write channel
		if (s.bvalid && s_axi_bready)
			next_s.bvalid = 1'b0;
		if (s_axi_awvalid && s.awready)
		begin
			next_s.awHeld = 1'b1;
			next_s.awAddr = s_axi_awaddr[11:0];
		end
		if (s_axi_wvalid && s.wready)
		begin
			next_s.wHeld = 1'b1;
			next_s.wData = s_axi_wdata[1:0];
			next_s.wStrb0 = s_axi_wstrb[0];
		end
		if (next_s.awHeld && next_s.wHeld && !next_s.bvalid)
		begin
			next_s.awHeld = 1'b0;
			next_s.wHeld = 1'b0;
			next_s.bvalid = 1'b1;
			if (hitReg(next_s.awAddr, CTRL_OFFSET))
			begin
				next_s.bresp = RESP_OKAY;
				if (next_s.wStrb0)
					next_s.modeSel = next_s.wData;
			end
			else if (hitReg(next_s.awAddr, STATUS_OFFSET))
				next_s.bresp = RESP_OKAY;
			else
				next_s.bresp = RESP_SLVERR;
		end
		next_s.awready = !next_s.awHeld && !next_s.bvalid;
		next_s.wready = !next_s.wHeld && !next_s.bvalid;

		// AXI4-Lite read channel
		if (s.rvalid && s_axi_rready)
			next_s.rvalid = 1'b0;
		if (s_axi_arvalid && s.arready)
		begin
			next_s.rvalid = 1'b1;
			next_s.rresp = RESP_OKAY;
			if (hitReg(s_axi_araddr[11:0], CTRL_OFFSET))
				next_s.rdata = {30'h0, s.modeSel};
			else if (hitReg(s_axi_araddr[11:0], STATUS_OFFSET))
				next_s.rdata = {15'h0, s.fullSeen, s.syncB, 3'h0, s.state};
			else
			begin
				next_s.rdata = 32'h0;
				next_s.rresp = RESP_SLVERR;
			end
		end
		next_s.arready = !next_s.rvalid;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s <= '0;
			s.state <= ST_START;
			s.modeSel <= MODE_RESET;
			s.coilLimit <= COIL_LIMIT_RESET;
			s.analogEn <= 1'b1;
		end
		else
			s <= next_s;
	end

	// ==========================================================
	// Outputs
	assign inputHighSwitch = s.inHigh;
	assign outputHighSwitch = s.outHigh;
	assign switchEnable = s.swEn;
	assign dutyRamp = s.ramp;
	assign fillerPulse = s.filler;
	assign analogEnable = s.analogEn;
	assign ocDetectEnable = s.ocDetEn;
	assign coilLimit = s.coilLimit;
	assign ctrlState = s.state;
	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bresp = s.bresp;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_arready = s.arready;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign s_axi_rvalid = s.rvalid;

	// ==========================================================
	// Checks
	logic [31:0] swCnt;
	logic [31:0] enterCnt;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			swCnt <= 32'h0;
			enterCnt <= 32'h0;
		end
		else
		begin
			swCnt <= (s.state == ST_SWITCH) ? swCnt + 32'h1 : 32'h0;
			enterCnt <= (s.state == ST_ENTER) ? enterCnt + 32'h1 : 32'h0;
		end
	end

	a_start_switching: assert property (@(posedge clk) disable iff (!rstn)
		s.state == ST_START && $past(por) && por |-> s.swEn && !s.ocDetEn)
		else $error("switching off during start-up");
	a_idle_without_power: assert property (@(posedge clk) disable iff (!rstn)
		!$past(por) |-> !s.swEn && !s.inHigh && !s.outHigh)
		else $error("power stage driven below power-on level");
	a_coil_ramp: assert property (@(posedge clk) disable iff (!rstn)
		s.state == ST_START && $past(s.state) == ST_START |-> s.coilLimit == $past(s.coilLimit)
		|| s.coilLimit == $past(s.coilLimit) + 4'h1 || s.coilLimit == COIL_LIMIT_RESET)
		else $error("coil limit jumped during start-up");
	a_pass_switches: assert property (@(posedge clk) disable iff (!rstn)
		s.state == ST_PASS |-> s.inHigh && s.outHigh && !s.swEn)
		else $error("high switches not closed in pass-through");
	a_enter_gate: assert property (@(posedge clk) disable iff (!rstn)
		s.state == ST_ENTER && $past(s.state) == ST_SWITCH
		|-> $past(s.modeSel) == MODE_PASSTHROUGH && !$past(uv) && !$past(ov))
		else $error("pass-through entered without permission");
	a_pass_exit: assert property (@(posedge clk) disable iff (!rstn)
		s.state == ST_PASS && por && (uv || ov || otw || oc) |=> s.state == ST_LEAVE)
		else $error("pass-through kept despite exit cause");
	a_min_active: assert property (@(posedge clk) disable iff (!rstn)
		s.state == ST_ENTER && $past(s.state) == ST_SWITCH |-> $past(swCnt) >= MIN_ACTIVE_CNT)
		else $error("pass-through retried before minimum-active time");
	a_trans_time: assert property (@(posedge clk) disable iff (!rstn)
		s.state == ST_PASS && $past(s.state) == ST_ENTER
		|-> $past(enterCnt) >= TRANSITION_CNT && !s.analogEn && s.ocDetEn)
		else $error("pass-through reached before transition time");
	a_full_duty: assert property (@(posedge clk) disable iff (!rstn)
		s.state == ST_ENTER && s.fullSeen |-> !s.swEn && s.ramp)
		else $error("switching continued at full duty");
	a_leave_hold: assert property (@(posedge clk) disable iff (!rstn)
		s.state == ST_LEAVE && por && !below |=> s.state == ST_LEAVE && s.analogEn && !s.swEn)
		else $error("switching resumed before output fell");
	a_filler_cause: assert property (@(posedge clk) disable iff (!rstn)
		$rose(s.filler) |-> $past(bootLow) && s.inHigh)
		else $error("filler pulse without low bootstrap");

	c_pass_reached: cover property (@(posedge clk) disable iff (!rstn)
		s.state == ST_ENTER ##1 s.state == ST_PASS);
	c_oc_cycle: cover property (@(posedge clk) disable iff (!rstn)
		s.state == ST_PASS && oc ##1 s.state == ST_LEAVE);
	c_leave_resume: cover property (@(posedge clk) disable iff (!rstn)
		s.state == ST_LEAVE ##1 s.state == ST_SWITCH);
endmodule // smps_mode_ctrl

// ==== logic/smps_pt_pkg.sv ====
// Constants, state codes and register map of the converter mode controller.
// Assumes a 200 MHz system clock; all times are converted to cycles here.
package smps_pt_pkg;

	// ==========================================================
	// Clock and timing
	localparam int unsigned CLK_PERIOD_PS = 5000;
	localparam int unsigned MIN_ACTIVE_TIME_US = 100;
	localparam int unsigned TRANSITION_TIME_US = 50;
	localparam int unsigned SOFT_STEP_TIME_NS = 1000;
	localparam int unsigned FILL_GAP_TIME_NS = 2000;
	localparam int unsigned FILL_WIDTH_TIME_NS = 50;
	localparam int unsigned MIN_ACTIVE_CYCLES =
		(MIN_ACTIVE_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned TRANSITION_CYCLES =
		(TRANSITION_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned SOFT_STEP_CYCLES =
		(SOFT_STEP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [8:0] FILL_GAP_CYCLES = 9'(
		(FILL_GAP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [3:0] FILL_WIDTH_CYCLES = 4'(
		(FILL_WIDTH_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [3:0] COIL_LIMIT_MAX = 4'hf;
	localparam logic [3:0] COIL_LIMIT_RESET = 4'h0;

	// ==========================================================
	// Register map and fields
	localparam logic [11:0] CTRL_OFFSET = 12'h000;
	localparam logic [11:0] STATUS_OFFSET = 12'h004;
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [1:0] MODE_PASSTHROUGH = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Indicator pin positions within the raw input vector
	localparam int IDX_POR = 0;
	localparam int IDX_UV = 1;
	localparam int IDX_OV = 2;
	localparam int IDX_OTW = 3;
	localparam int IDX_OC = 4;
	localparam int IDX_FULL = 5;
	localparam int IDX_BOOT = 6;
	localparam int IDX_BELOW = 7;

	typedef enum logic [4:0] {
		ST_START = 5'h01,
		ST_SWITCH = 5'h02,
		ST_ENTER = 5'h04,
		ST_PASS = 5'h08,
		ST_LEAVE = 5'h10
	} ctrl_state_e;

endpackage

// ==== logic/timer_if.sv ====
// Load/expiry handshake between the mode controller and a sequence timer.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface timer_if;
	logic load;
	logic done;
	modport ctrl (output load, input done);
	modport tmr (input load, output done);
endinterface

// ==== tb/power_stage_model.sv ====
// Behavioural power stage: duty ramp, output fall while leaving, bootstrap droop.
// Assumes the controller outputs are registered on the same clock.
`timescale 1ns/1ps
module power_stage_model #(
	parameter int FULL_DLY = 6,
	parameter int FALL_DLY = 8,
	parameter int DROOP = 150
)(
	input wire logic clk,
	input wire logic dutyRamp,
	input wire logic inputHighSwitch,
	input wire logic analogEnable,
	input wire logic switchEnable,
	input wire logic fillerPulse,
	output logic full,
	output logic bootLow,
	output logic below
);
	// ==========================================================
	// Analog behaviour
	int rampCnt = 0;
	int fallCnt = 0;
	int chargeCnt = 0;
	logic leaving;
	assign leaving = analogEnable && !switchEnable && !inputHighSwitch && !dutyRamp;
	always @(posedge clk)
	begin
		rampCnt <= dutyRamp ? rampCnt + 1 : 0;
		fallCnt <= leaving ? fallCnt + 1 : 0;
		// Charge leaks only while the high switches sit closed
		chargeCnt <= (inputHighSwitch && !fillerPulse) ? chargeCnt + 1 : 0;
	end
	assign full = inputHighSwitch || rampCnt >= FULL_DLY;
	assign below = fallCnt >= FALL_DLY;
	assign bootLow = chargeCnt >= DROOP;
endmodule // power_stage_model

// ==== tb/smps_mode_ctrl_tb.sv ====
// Self-checking bench of the converter mode controller.
// Assumes the power stage model answers the ramp, leave and bootstrap indicators.
`timescale 1ns/1ps
module smps_mode_ctrl_tb;
	import smps_pt_pkg::*;
	localparam int MIN_A = 20;
	logic clk = 0;
	logic rstn = 0;
	logic [4:0] pins = '0;
	logic full, bootLow, below, inHi, outHi, swEn, ramp, fill, anEn, ocEn;
	logic [3:0] coil;
	logic [4:0] st;
	logic [4:0] prevSt = ST_START;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
	logic [3:0] wstrb = '0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [7:0] seed = 8'h4e;
	logic [4:0] stQ[$];
	logic [3:0] rspQ[$];
	int num_errors = 0, n_compared = 0, cyc = 0;

	always #2.5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	smps_mode_ctrl #(.MIN_ACTIVE_CNT(MIN_A), .TRANSITION_CNT(10)) smps_mode_ctrl_inst (
		.clk(clk), .rstn(rstn), .indicatorPins({below, bootLow, full, pins}),
		.inputHighSwitch(inHi), .outputHighSwitch(outHi), .switchEnable(swEn),
		.dutyRamp(ramp), .fillerPulse(fill), .analogEnable(anEn), .ocDetectEnable(ocEn),
		.coilLimit(coil), .ctrlState(st), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

	power_stage_model power_stage_model_inst (.clk(clk), .dutyRamp(ramp),
		.inputHighSwitch(inHi), .analogEnable(anEn), .switchEnable(swEn),
		.fillerPulse(fill), .full(full), .bootLow(bootLow), .below(below));

	// ==========================================================
	// Helpers
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("compared=%0d errors=%0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic bail(input logic bad);
		if (bad)
		begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, st, stQ.size());
			print_verdict();
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic waitQ(input int left, input int lim);
		for (int i = 0; i < lim && stQ.size() > left; i++)
			@(posedge clk);
		bail(stQ.size() > left);
	endtask
	task automatic axiWr(input logic [31:0] a, input logic [1:0] m, input logic [3:0] s,
		input logic [1:0] r);
		int i;
		rspQ.push_back({r, 2'h0});
		seed = lfsr(seed);
		@(posedge clk);
		awaddr <= a;
		wdata <= {{3{seed}}, seed[5:0], m};
		wstrb <= s;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		for (i = 0; i < 100; i++)
		begin
			@(posedge clk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			if (bvalid) break;
		end
		bready <= 0;
		bail(i >= 100);
	endtask
	task automatic axiRd(input logic [31:0] a, input logic [3:0] e);
		int i;
		rspQ.push_back(e);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		for (i = 0; i < 100; i++)
		begin
			@(posedge clk);
			if (arready) arvalid <= 0;
			if (rvalid) break;
		end
		rready <= 0;
		bail(i >= 100);
	endtask
	task automatic leaveSw();
		stQ.push_back(ST_LEAVE);
		stQ.push_back(ST_SWITCH);
	endtask
	task automatic enterPass();
		stQ.push_back(ST_ENTER);
		stQ.push_back(ST_PASS);
		axiWr(32'(CTRL_OFFSET), MODE_PASSTHROUGH, 4'hf, RESP_OKAY);
		waitQ(0, 500);
	endtask

	// ==========================================================
	// Monitor: every state change and bus answer takes the oldest note
	always @(posedge clk)
	begin
		if (rstn && st !== prevSt)
			chk({3'h0, st}, {3'h0, stQ.size() > 0 ? stQ.pop_front() : 5'h1f});
		if (bvalid && bready)
			chk({4'h0, bresp, 2'h0}, {4'h0, rspQ.pop_front()});
		if (rvalid && rready)
			chk({4'h0, rresp, rdata[1:0]}, {4'h0, rspQ.pop_front()});
		prevSt <= st;
	end

	// ==========================================================
	// Sequence
	initial
	begin
		int t0;
		int cnt;
		logic lastFill;
		tick(6);
		chk({3'h0, st}, {3'h0, ST_START});
		chk({2'h0, anEn, ocEn, coil}, 8'h20);
		rstn <= 1;
		tick(2);
		axiRd(32'(CTRL_OFFSET), {RESP_OKAY, MODE_RESET});
		axiRd(32'h10, {RESP_SLVERR, 2'h0});
		t0 = cyc;
		pins[IDX_POR] <= 1;
		stQ.push_back(ST_SWITCH);
		waitQ(0, 5000);
		chk({4'h0, coil}, {4'h0, COIL_LIMIT_MAX});
		chk(8'(cyc - t0 >= 3000), 8'h1);
		axiRd(32'(STATUS_OFFSET), {RESP_OKAY, 2'h2});
		enterPass();
		chk({2'h0, ramp, inHi, outHi, swEn, anEn, ocEn}, 8'h19);
		cnt = 0;
		lastFill = 0;
		repeat (1000)
		begin
			@(posedge clk);
			cnt += (fill && !lastFill);
			lastFill = fill;
		end
		chk(8'(cnt >= 1 && cnt <= 3), 8'h1);
		// Persistent overcurrent cycles between switching and pass-through
		axiWr(32'(CTRL_OFFSET), MODE_PASSTHROUGH, 4'hf, RESP_OKAY);
		pins[IDX_OC] <= 1;
		leaveSw();
		stQ.push_back(ST_ENTER);
		stQ.push_back(ST_PASS);
		leaveSw();
		waitQ(5, 200);
		chk({5'h0, inHi, swEn, anEn}, 8'h1);
		waitQ(4, 200);
		t0 = cyc;
		waitQ(3, 200);
		chk(8'(cyc - t0 >= MIN_A), 8'h1);
		chk({6'h0, ramp, swEn}, 8'h3);
		waitQ(0, 500);
		pins[IDX_OC] <= 0;
		enterPass();
		for (int i = IDX_UV; i <= IDX_OTW; i++)
		begin
			pins[i] <= 1;
			leaveSw();
			waitQ(0, 500);
			tick(40);
			pins[i] <= 0;
			enterPass();
		end
		for (int i = 0; i < 3; i++)
		begin
			leaveSw();
			axiWr(32'(CTRL_OFFSET), 2'(i), 4'h1, RESP_OKAY);
			waitQ(0, 500);
			t0 = cyc;
			axiRd(32'(CTRL_OFFSET), {RESP_OKAY, 2'(i)});
			enterPass();
			chk(8'(cyc - t0 >= MIN_A + 10), 8'h1);
		end
		axiWr(32'(CTRL_OFFSET), 2'h0, 4'h0, RESP_OKAY);
		axiRd(32'(CTRL_OFFSET), {RESP_OKAY, MODE_PASSTHROUGH});
		axiWr(32'(STATUS_OFFSET), 2'h0, 4'hf, RESP_OKAY);
		axiWr(32'h20, 2'h0, 4'hf, RESP_SLVERR);
		tick(40);
		pins[IDX_POR] <= 0;
		stQ.push_back(ST_START);
		waitQ(0, 50);
		chk({4'h0, coil}, 8'h0);
		chk(8'(stQ.size() + rspQ.size()), 8'h0);
		print_verdict();
	end
endmodule // smps_mode_ctrl_tb
